// [logic/mpst_engine.v]
// Function
// R1 - The engine writes a pseudo-random pattern to memory at full rate in each write phase.
// R2 - Writes cover every address and reading starts only after the final address is written.
// R3 - Each word read back is compared against the expected pattern value for its address.
// R4 - Any miscompare changes the state of a dedicated error indicator output; the code sets error_reg on the first miscompare and holds it until reset.
// R5 - One test is counted each time a full write phase and a full read phase finish.
// R6 - The two low hex digits of the test counter drive the two seven-segment outputs.
// R7 - The DDR variant runs a finite number of tests taken from switch inputs 6 to 15.
// R8 - In the DDR variant a switch limit of zero means a run of 65536 tests.
// R9 - The RLDRAM variant has a fixed limit of hex 80, that is 128 tests.
// R10 - The pattern generator restarts from the same seed at the start of each read phase.
// R11 - At the limit the engine stops memory operations, holds the count and asserts done.
`timescale 1ns/1ps
`include "mpst_consts.vh"
module mpst_engine #(
   parameter ADDR_W = `MPST_ADDR_W,
   parameter DATA_W = `MPST_DATA_W,
   parameter FIXED_LIMIT = 0
)(
   input wire mclk,
   input wire rst,
   input wire start,
   input wire [15:0] user_sw,
   output reg mem_wr_reg,
   output reg mem_rd_reg,
   output reg [ADDR_W-1:0] mem_addr_reg,
   output reg [DATA_W-1:0] mem_wdata_reg,
   input wire mem_ready,
   input wire mem_rvalid,
   input wire [DATA_W-1:0] mem_rdata,
   output wire [6:0] seg_lo,
   output wire [6:0] seg_hi,
   output reg error_reg,
   output reg done_reg,
   output wire busy
);
   // Sequencer states; S_DONE is left only through reset.
   localparam S_IDLE = 2'h0;
   localparam S_WRITE = 2'h1;
   localparam S_READ = 2'h2;
   localparam S_DONE = 2'h3;
   localparam [ADDR_W-1:0] LAST_ADDR = {ADDR_W{1'b1}};
   localparam [31:0] SEED = `MPST_SEED;

   ////////////////////////////////////////////////////////////////////////////////
   // Galois LFSR step, taps 32,22,2,1; used by both generators.
   function [31:0] lfsr_step;
      input [31:0] v;
      begin
         lfsr_step = {1'b0, v[31:1]} ^ (v[0] ? `MPST_LFSR_TAPS : 32'h00000000);
      end
   endfunction

   // Seven-segment decode of one hex digit, segments gfedcba, active high.
   function [6:0] hex_seg;
      input [3:0] d;
      begin
         case (d)
            4'h0: hex_seg = 7'h3F;
            4'h1: hex_seg = 7'h06;
            4'h2: hex_seg = 7'h5B;
            4'h3: hex_seg = 7'h4F;
            4'h4: hex_seg = 7'h66;
            4'h5: hex_seg = 7'h6D;
            4'h6: hex_seg = 7'h7D;
            4'h7: hex_seg = 7'h07;
            4'h8: hex_seg = 7'h7F;
            4'h9: hex_seg = 7'h6F;
            4'hA: hex_seg = 7'h77;
            4'hB: hex_seg = 7'h7C;
            4'hC: hex_seg = 7'h39;
            4'hD: hex_seg = 7'h5E;
            4'hE: hex_seg = 7'h79;
            default: hex_seg = 7'h71;
         endcase
      end
   endfunction

   // Widen the 32-bit pattern to the data width by repetition.
   function [DATA_W-1:0] widen;
      input [31:0] v;
      integer i;
      begin
         widen = {DATA_W{1'b0}};
         for (i = 0; i < DATA_W; i = i + 1)
            widen[i] = v[i % 32];
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Write and read generators run apart, so read returns may trail the requests.
   reg [1:0] state_reg;
   reg [31:0] wgen_reg;
   reg [31:0] rgen_reg;
   reg [ADDR_W-1:0] rd_cnt_reg;
   reg [`MPST_CNT_W-1:0] pass_reg;
   wire [`MPST_CNT_W-1:0] limit;
   wire [`MPST_SW_W-1:0] sw_limit;
   wire issue_done;
   wire read_hit;
   wire [`MPST_CNT_W-1:0] pass_next;
   wire limit_hit;

   // The limit is sampled live so a switch change mid-run takes effect at the next pass.
   assign sw_limit = user_sw[`MPST_SW_LSB+`MPST_SW_W-1:`MPST_SW_LSB]; // R7
   assign limit = (FIXED_LIMIT != 0) ? `MPST_FIXED_RUN : // R9
                  (sw_limit == {`MPST_SW_W{1'b0}}) ? `MPST_ZERO_RUN : // R8
                  {{(`MPST_CNT_W-`MPST_SW_W){1'b0}}, sw_limit}; // R7
   // Last-address strobes: one for a taken request, one for a returned word.
   assign issue_done = mem_ready && (mem_addr_reg == LAST_ADDR);
   assign read_hit = mem_rvalid && (rd_cnt_reg == LAST_ADDR);
   assign busy = (state_reg == S_WRITE) || (state_reg == S_READ);
   // Compared with >= so that switches lowered below the count mid-run still end the run.
   assign pass_next = pass_reg + 1'b1; // R5
   assign limit_hit = (pass_next >= limit); // R11
   // The displays follow the counter directly and freeze with it once done.
   assign seg_lo = hex_seg(pass_reg[3:0]); // R6
   assign seg_hi = hex_seg(pass_reg[7:4]); // R6

   ////////////////////////////////////////////////////////////////////////////////
   // Sequencer; a request stands until the memory takes it with mem_ready.
   always @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         // Everything resets together, the generators to SEED and the rest to zero, so the displays read 00 after reset.
         state_reg <= S_IDLE;
         mem_wr_reg <= 1'b0;
         mem_rd_reg <= 1'b0;
         mem_addr_reg <= {ADDR_W{1'b0}};
         mem_wdata_reg <= {DATA_W{1'b0}};
         wgen_reg <= SEED;
         rgen_reg <= SEED;
         rd_cnt_reg <= {ADDR_W{1'b0}};
         pass_reg <= {`MPST_CNT_W{1'b0}};
         error_reg <= 1'b0;
         done_reg <= 1'b0;
      end
      else
      begin
         case (state_reg)
            S_IDLE:
            begin
               // A run starts only from idle; start is ignored while running or done.
               if (start)
               begin
                  state_reg <= S_WRITE;
                  mem_wr_reg <= 1'b1; // R1
                  mem_addr_reg <= {ADDR_W{1'b0}};
                  mem_wdata_reg <= widen(SEED);
                  wgen_reg <= lfsr_step(SEED);
               end
            end
            S_WRITE:
            begin
               if (mem_ready)
               begin
                  // Back-to-back writes, one per accepted cycle.
                  mem_addr_reg <= mem_addr_reg + 1'b1; // R2
                  mem_wdata_reg <= widen(wgen_reg); // R1
                  wgen_reg <= lfsr_step(wgen_reg);
                  if (issue_done)
                  begin
                     // Read phase only after the last address is taken.
                     state_reg <= S_READ; // R2
                     mem_wr_reg <= 1'b0;
                     mem_rd_reg <= 1'b1;
                     mem_addr_reg <= {ADDR_W{1'b0}};
                     rgen_reg <= SEED; // R10
                     rd_cnt_reg <= {ADDR_W{1'b0}};
                  end
               end
            end
            S_READ:
            begin
               // The read request drops once the last address is taken; replies may trail.
               if (mem_rd_reg && issue_done)
                  mem_rd_reg <= 1'b0;
               else if (mem_ready && mem_rd_reg)
                  mem_addr_reg <= mem_addr_reg + 1'b1;
               // Read data returns in address order; compare against the replayed pattern.
               if (mem_rvalid)
               begin
                  rd_cnt_reg <= rd_cnt_reg + 1'b1;
                  rgen_reg <= lfsr_step(rgen_reg);
                  // The error flag is sticky, so one bad word in a long run stays visible.
                  if (mem_rdata != widen(rgen_reg)) // R3
                     error_reg <= 1'b1; // R4
                  // The last word closes the pass; the limit picks done or a fresh pass.
                  if (read_hit)
                  begin
                     pass_reg <= pass_next; // R5
                     if (limit_hit)
                     begin
                        state_reg <= S_DONE; // R11
                        done_reg <= 1'b1; // R11
                     end
                     else
                     begin
                        state_reg <= S_WRITE;
                        mem_wr_reg <= 1'b1;
                        mem_addr_reg <= {ADDR_W{1'b0}};
                        mem_wdata_reg <= widen(SEED);
                        wgen_reg <= lfsr_step(SEED);
                     end
                  end
               end
            end
            S_DONE:
            begin
               // Held until reset; no further memory traffic.
               mem_wr_reg <= 1'b0; // R11
               mem_rd_reg <= 1'b0; // R11
            end
            // Unused codes fall back to idle rather than lock up.
            default:
               state_reg <= S_IDLE;
         endcase
      end
   end
endmodule // mpst_engine

// [logic/mpst_consts.vh]
`ifndef MPST_CONSTS_VH
`define MPST_CONSTS_VH
// Default memory address width and data width.
`define MPST_ADDR_W 16
`define MPST_DATA_W 32
// Width of the completed-test counter, wide enough for 65536.
`define MPST_CNT_W 17
// Switch field position and width for the run limit.
`define MPST_SW_LSB 6
`define MPST_SW_W 10
// Run length used when the switch field is zero.
`define MPST_ZERO_RUN 17'h10000
// Fixed stop count of the RLDRAM variant.
`define MPST_FIXED_RUN 17'h00080
// Pattern generator seed, any nonzero value.
`define MPST_SEED 32'hACE1ACE1
// Feedback mask of the pattern generator, taps 32, 22, 2 and 1.
`define MPST_LFSR_TAPS 32'h80200003
`endif

// [testbench/mpst_engine_chk.sv]
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Watches memory requests and indicators of the test engine.
module mpst_engine_chk #(
   parameter ADDR_W = 16,
   parameter DATA_W = 32
)(
   input wire mclk,
   input wire rst,
   input wire mem_wr_reg,
   input wire mem_rd_reg,
   input wire [ADDR_W-1:0] mem_addr_reg,
   input wire [DATA_W-1:0] mem_wdata_reg,
   input wire mem_ready,
   input wire mem_rvalid,
   input wire [6:0] seg_lo,
   input wire [6:0] seg_hi,
   input wire error_reg,
   input wire done_reg
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // A stalled request must stand, or a word would be lost.
   req_hold_a: assert property ((mem_wr_reg || mem_rd_reg) && !mem_ready |=>
      $stable({mem_wr_reg, mem_rd_reg, mem_addr_reg, mem_wdata_reg})) else $error("req moved");
   wr_step_a: assert property (mem_wr_reg && mem_ready && !(&mem_addr_reg) |=>
      mem_wr_reg && mem_addr_reg == $past(mem_addr_reg) + 1'b1) else $error("wr skip");
   rd_start_a: assert property (mem_wr_reg && mem_ready && (&mem_addr_reg) |=>
      ##[0:3] mem_rd_reg && mem_addr_reg == 0) else $error("no rd start");
   wr_rd_excl_a: assert property (!(mem_wr_reg && mem_rd_reg)) else $error("wr and rd");
   err_keep_a: assert property (error_reg |=> error_reg) else $error("err lost");
   err_cause_a: assert property ($rose(error_reg) |->
      $past(mem_rvalid) || $past(mem_rvalid, 2)) else $error("err no read");
   done_quiet_a: assert property (done_reg |-> !mem_wr_reg && !mem_rd_reg) else $error("busy");
   done_hold_a: assert property (done_reg |=> done_reg && $stable({seg_lo, seg_hi}))
      else $error("done moved");
   cover property (done_reg && !error_reg);
   cover property ($rose(error_reg));
   cover property (mem_wr_reg && !mem_ready);
   cover property (mem_rd_reg && !mem_ready);
endmodule // mpst_engine_chk
bind mpst_engine mpst_engine_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_chk (.mclk(mclk),
   .rst(rst), .mem_wr_reg(mem_wr_reg), .mem_rd_reg(mem_rd_reg), .mem_addr_reg(mem_addr_reg),
   .mem_wdata_reg(mem_wdata_reg), .mem_ready(mem_ready), .mem_rvalid(mem_rvalid),
   .seg_lo(seg_lo), .seg_hi(seg_hi), .error_reg(error_reg), .done_reg(done_reg));

// [testbench/mpst_mem_model.sv]
`timescale 1ns/1ps
// Memory behind the engine; slow toggles ready, bad flips bit 0 of reads.
module mpst_mem_model #(parameter AW = 2)(
   input wire mclk,
   input wire rst,
   input wire wr,
   input wire rd,
   input wire [AW-1:0] addr,
   input wire [31:0] wdata,
   input wire slow,
   input wire bad,
   output reg ready,
   output reg rvalid,
   output reg [31:0] rdata
);
   reg [31:0] mem [0:(1<<AW)-1];
   // Idle read data is inverted each cycle so a stale word never looks valid.
   always @(posedge mclk or posedge rst)
      if (rst)
      begin
         ready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h00000000;
      end
      else
      begin
         ready <= slow ? ~ready : 1'b1;
         rvalid <= rd && ready;
         rdata <= (rd && ready) ? mem[addr] ^ {31'h0, bad} : ~rdata;
         if (wr && ready)
            mem[addr] <= wdata;
      end
endmodule // mpst_mem_model

// [testbench/mpst_engine_tb.sv]
`timescale 1ns/1ps
`include "mpst_consts.vh"
module mpst_engine_tb;
   reg mclk = 1'b0;
   reg rst = 1'b1;
   reg start = 1'b0;
   reg start_fix = 1'b0;
   reg slow = 1'b0;
   reg bad = 1'b0;
   reg [15:0] user_sw = 16'h0000;
   wire wr, rd, rdy, rv, err, dn, bsy;
   wire wr2, rd2, rdy2, rv2, err2, dn2, bsy2;
   wire [1:0] adr, adr2;
   wire [31:0] wd, rdt, wd2, rdt2;
   wire [6:0] sl, sh, sl2, sh2;
   integer num_errors = 0;
   integer checked = 0;
   integer i;
   always #20 mclk = ~mclk;
   mpst_engine #(.ADDR_W(2)) u_dut (.mclk(mclk), .rst(rst), .start(start), .user_sw(user_sw),
      .mem_wr_reg(wr), .mem_rd_reg(rd), .mem_addr_reg(adr), .mem_wdata_reg(wd),
      .mem_ready(rdy), .mem_rvalid(rv), .mem_rdata(rdt), .seg_lo(sl), .seg_hi(sh),
      .error_reg(err), .done_reg(dn), .busy(bsy));
   mpst_mem_model #(.AW(2)) u_mem (.mclk(mclk), .rst(rst), .wr(wr), .rd(rd), .addr(adr),
      .wdata(wd), .slow(slow), .bad(bad), .ready(rdy), .rvalid(rv), .rdata(rdt));
   // Second engine in the fixed-limit variant, started on its own strobe.
   mpst_engine #(.ADDR_W(2), .FIXED_LIMIT(1)) u_dut_fix (.mclk(mclk), .rst(rst),
      .start(start_fix), .user_sw(user_sw), .mem_wr_reg(wr2), .mem_rd_reg(rd2),
      .mem_addr_reg(adr2), .mem_wdata_reg(wd2), .mem_ready(rdy2), .mem_rvalid(rv2),
      .mem_rdata(rdt2), .seg_lo(sl2), .seg_hi(sh2), .error_reg(err2), .done_reg(dn2),
      .busy(bsy2));
   mpst_mem_model #(.AW(2)) u_mem_fix (.mclk(mclk), .rst(rst), .wr(wr2), .rd(rd2),
      .addr(adr2), .wdata(wd2), .slow(slow), .bad(bad), .ready(rdy2), .rvalid(rv2),
      .rdata(rdt2));
   task cmp(input [8*4:1] nm, input [31:0] e, input [31:0] g);
      begin
         checked = checked + 1;
         if (e !== g)
         begin
            $display("[FAIL] %0s expected %h seen %h", nm, e, g);
            num_errors = num_errors + 1;
         end
      end
   endtask
   // Expected word at an address: seed stepped once per address.
   function [31:0] pat(input [1:0] n);
      integer k;
      begin
         pat = `MPST_SEED;
         for (k = 0; k < n; k = k + 1)
            pat = pat[0] ? (pat >> 1) ^ `MPST_LFSR_TAPS : pat >> 1;
      end
   endfunction
   // Each write the memory takes must carry the word for its address.
   // Looked at on the falling edge, where a request about to be taken is settled.
   always @(negedge mclk)
   begin
      if (wr && rdy) cmp("wdat", pat(adr), wd);
      if (wr2 && rdy2) cmp("wdt2", pat(adr2), wd2);
   end
   task results;
      begin
         if (num_errors == 0 && checked > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   // Reset both engines, set the switch field and start the switch-limited engine.
   task run(input [9:0] lim);
      begin
         rst = 1'b1;
         user_sw = {lim, 6'h00};
         repeat (3) @(negedge mclk);
         rst = 1'b0;
         start = 1'b1;
         @(negedge mclk);
         start = 1'b0;
         cmp("busy", 32'h1, bsy);
      end
   endtask
   // Bounded wait for done; running out counts a mismatch and ends the run.
   task wait_done(input integer n);
      begin
         for (i = 0; i < n && dn !== 1'b1; i = i + 1)
            @(negedge mclk);
         if (dn !== 1'b1)
         begin
            cmp("done", 32'h1, dn);
            results;
         end
      end
   endtask
   // Three passes under the switch limit, then a start after done must be ignored.
   task test_limit;
      begin
         run(10'h003);
         wait_done(800);
         cmp("err", 32'h0, err);
         cmp("slo", 32'h4F, sl);
         cmp("shi", 32'h3F, sh);
         start = 1'b1;
         repeat (20) @(negedge mclk);
         start = 1'b0;
         cmp("slo", 32'h4F, sl);
         cmp("done", 32'h1, dn);
         cmp("busy", 32'h0, bsy);
      end
   endtask
   // One pass against a stalling memory whose read words come back corrupted.
   task test_error;
      begin
         slow = 1'b1;
         bad = 1'b1;
         run(10'h001);
         wait_done(800);
         cmp("err", 32'h1, err);
         cmp("slo", 32'h06, sl);
         slow = 1'b0;
         bad = 1'b0;
      end
   endtask
   // A zero switch field must keep the engine running well past the first passes.
   task test_zero;
      begin
         run(10'h000);
         repeat (3000) @(negedge mclk);
         cmp("done", 32'h0, dn);
         cmp("busy", 32'h1, bsy);
         cmp("err", 32'h0, err);
      end
   endtask
   // The fixed-limit engine ignores the switches and stops with 80 on the display.
   task test_fixed;
      begin
         rst = 1'b1;
         user_sw = {10'h002, 6'h00};
         repeat (3) @(negedge mclk);
         rst = 1'b0;
         start_fix = 1'b1;
         @(negedge mclk);
         start_fix = 1'b0;
         cmp("bsy2", 32'h1, bsy2);
         for (i = 0; i < 3000 && dn2 !== 1'b1; i = i + 1)
            @(negedge mclk);
         cmp("dn2", 32'h1, dn2);
         cmp("sl2", 32'h3F, sl2);
         cmp("sh2", 32'h7F, sh2);
         cmp("err2", 32'h0, err2);
      end
   endtask
   initial
   begin
      test_limit;
      test_error;
      test_zero;
      test_fixed;
      results;
   end
endmodule // mpst_engine_tb
